// *** hw/sofc_top.v ***
`include "sofc_defines.vh"
`default_nettype none
module sofc_top #(
	parameter W         = 24,
	parameter FRAC      = 8,
	parameter SHIFT_OFS = 1,
	parameter CW        = 20
) (
	input  wire                clk,
	input  wire                arst_n,
	input  wire                setup_wr,
	input  wire [7:0]          setup_opt_in,
	input  wire [7:0]          setup_dig_in,
	input  wire                alarm_enable_command,
	input  wire                alarm_disable_command,
	input  wire                low_alarm_command,
	input  wire                low_latch_in,
	input  wire                high_alarm_command,
	input  wire                high_latch_in,
	input  wire                variant_tc,
	input  wire                variant_rtd,
	input  wire                variant_temp,
	input  wire [1:0]          do_cmd,
	input  wire                alarm_lo,
	input  wire                alarm_hi,
	input  wire                rx_valid,
	input  wire [7:0]          rx_char,
	input  wire [CW-1:0]       char_time,
	input  wire                resp_request,
	input  wire                sample_valid,
	input  wire signed [W-1:0] sample,
	input  wire                read_req,
	output reg  [7:0]          setup_opt,
	output reg  [7:0]          setup_dig,
	output reg  [1:0]          terminal_out,
	output reg                 latch_lo,
	output reg                 latch_hi,
	output reg                 cjc_disable,
	output reg                 four_wire,
	output reg                 fahrenheit,
	output reg                 echo_valid,
	output reg  [7:0]          echo_char,
	output reg                 cmd_char_valid,
	output reg  [7:0]          cmd_char,
	output reg                 cmd_end,
	output reg                 resp_wait,
	output reg                 resp_start,
	output reg  signed [W-1:0] filt_out,
	output reg                 filt_valid,
	output reg                 large_sel,
	output reg  signed [W-1:0] reply_value,
	output reg                 reply_valid
);
	localparam ST_IDLE  = 2'h0;
	localparam ST_COUNT = 2'h1;
	localparam ST_GO    = 2'h2;

	// Weight of least displayed digit, in hundredths
	function [W-1:0] digit_weight;
		input [1:0] ndig;
		begin
			case (ndig)
			2'h0: digit_weight = `SOFC_WEIGHT_4DIG;
			2'h1: digit_weight = `SOFC_WEIGHT_5DIG;
			2'h2: digit_weight = `SOFC_WEIGHT_6DIG;
			default: digit_weight = `SOFC_WEIGHT_7DIG;
			endcase
		end
	endfunction

	reg  [7:0]          opt_reg;
	reg  [7:0]          opt_next;
	reg  [7:0]          dig_reg;
	reg                 after_cr_reg;
	reg  [1:0]          state_reg;
	reg  [2:0]          units_reg;
	reg  [CW-1:0]       cyc_reg;
	reg  signed [W-1:0] scaled_reg;
	reg                 scaled_valid_reg;
	wire signed [W-1:0] filt_value;
	wire                filt_valid_w;
	wire                large_sel_w;
	wire signed [W-1:0] mask_value;
	wire                mask_valid;
	wire [1:0]          ndig = dig_reg[`SOFC_DIG_NDIG_HI:`SOFC_DIG_NDIG_LO];
	wire [W-1:0]        weight = digit_weight(ndig);
	wire [W-1:0]        thresh = weight * `SOFC_THRESH_COUNTS;
	wire [2:0]          dly_units = {opt_reg[`SOFC_OPT_DLY_HI:
	                                 `SOFC_OPT_DLY_LO], 1'b0};
	wire [CW-1:0]       unit_len = (char_time == {CW{1'b0}}) ?
	                               {{(CW-1){1'b0}}, 1'b1} : char_time;
	wire                fahr_on = opt_reg[`SOFC_OPT_FAHR] & variant_temp;
	// Signed so that readings below zero divide toward zero
	wire signed [W+4:0] fahr_wide = ($signed({{5{filt_out[W-1]}},
	                                 filt_out}) * 29'sd9) / 29'sd5;
	wire signed [W-1:0] fahr_val = fahr_wide[W-1:0] + `SOFC_FAHR_OFFSET;

	// Setup write first; alarm commands override their own bits after it
	always @* begin
		opt_next = opt_reg;
		if (setup_wr)
			opt_next = setup_opt_in;
		if (alarm_enable_command)
			opt_next[`SOFC_OPT_ALARM_EN] = 1'b1;
		if (alarm_disable_command)
			opt_next[`SOFC_OPT_ALARM_EN] = 1'b0;
		if (low_alarm_command)
			opt_next[`SOFC_OPT_LO_LATCH] = low_latch_in;
		if (high_alarm_command)
			opt_next[`SOFC_OPT_HI_LATCH] = high_latch_in;
	end

	// The write is taken at any time, the filter sees it next sample
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			opt_reg <= `SOFC_OPT_RESET;
			dig_reg <= `SOFC_DIG_RESET;
		end else begin
			opt_reg <= opt_next;
			if (setup_wr)
				dig_reg <= setup_dig_in;
		end
	end

	// Option decodes and shared terminal routing
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			setup_opt <= `SOFC_OPT_RESET;
			setup_dig <= `SOFC_DIG_RESET;
			terminal_out <= 2'h0;
			latch_lo <= 1'b0;
			latch_hi <= 1'b0;
			cjc_disable <= 1'b0;
			four_wire <= 1'b0;
			fahrenheit <= 1'b0;
		end else begin
			setup_opt <= opt_reg;
			setup_dig <= dig_reg;
			if (opt_reg[`SOFC_OPT_ALARM_EN])
				terminal_out <= {alarm_hi, alarm_lo};
			else
				terminal_out <= do_cmd;
			latch_lo <= opt_reg[`SOFC_OPT_LO_LATCH];
			latch_hi <= opt_reg[`SOFC_OPT_HI_LATCH];
			cjc_disable <= variant_tc &
			               opt_reg[`SOFC_OPT_SENSOR];
			four_wire <= variant_rtd &
			             opt_reg[`SOFC_OPT_SENSOR];
			fahrenheit <= fahr_on;
		end
	end

	// Receive path: echo and command framing
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			echo_valid <= 1'b0;
			echo_char <= 8'h00;
			cmd_char_valid <= 1'b0;
			cmd_char <= 8'h00;
			cmd_end <= 1'b0;
			after_cr_reg <= 1'b0;
		end else begin
			echo_valid <= rx_valid & opt_reg[`SOFC_OPT_ECHO];
			cmd_char_valid <= 1'b0;
			cmd_end <= 1'b0;
			if (rx_valid) begin
				echo_char <= rx_char;
				after_cr_reg <= (rx_char == `SOFC_CHAR_CR);
				if (rx_char == `SOFC_CHAR_CR)
					cmd_end <= 1'b1;
				else if (!(after_cr_reg &&
				         rx_char == `SOFC_CHAR_LF)) begin
					cmd_char_valid <= 1'b1;
					cmd_char <= rx_char;
				end
			end
		end
	end

	// Turn-around delay counted from the end of processing
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			units_reg <= 3'h0;
			cyc_reg <= {CW{1'b0}};
			resp_wait <= 1'b0;
			resp_start <= 1'b0;
		end else begin
			resp_start <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (resp_request) begin
					resp_wait <= 1'b1;
					units_reg <= dly_units;
					cyc_reg <= unit_len;
					if (dly_units == 3'h0)
						state_reg <= ST_GO;
					else
						state_reg <= ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (cyc_reg == {{(CW-1){1'b0}}, 1'b1}) begin
					cyc_reg <= unit_len;
					units_reg <= units_reg - 3'h1;
					if (units_reg == 3'h1)
						state_reg <= ST_GO;
				end else begin
					cyc_reg <= cyc_reg - {{(CW-1){1'b0}}, 1'b1};
				end
			end
			ST_GO: begin
				resp_start <= 1'b1;
				resp_wait <= 1'b0;
				state_reg <= ST_IDLE;
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	sofc_filter #(
		.W         (W),
		.FRAC      (FRAC),
		.SHIFT_OFS (SHIFT_OFS)
	) u_filter (
		.clk          (clk),
		.arst_n       (arst_n),
		.sample_valid (sample_valid),
		.sample       (sample),
		.large_code   (dig_reg[`SOFC_DIG_LARGE_HI:`SOFC_DIG_LARGE_LO]),
		.small_code   (dig_reg[`SOFC_DIG_SMALL_HI:`SOFC_DIG_SMALL_LO]),
		.thresh       (thresh),
		.filt_value   (filt_value),
		.filt_valid   (filt_valid_w),
		.large_sel    (large_sel_w)
	);

	// Unmasked reading held for other users; scale only on read replies
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			filt_out <= {W{1'b0}};
			filt_valid <= 1'b0;
			large_sel <= 1'b0;
			scaled_reg <= {W{1'b0}};
			scaled_valid_reg <= 1'b0;
		end else begin
			filt_valid <= filt_valid_w;
			if (filt_valid_w) begin
				filt_out <= filt_value;
				large_sel <= large_sel_w;
			end
			scaled_valid_reg <= read_req;
			if (read_req)
				scaled_reg <= fahr_on ? fahr_val : filt_out;
		end
	end

	sofc_mask #(
		.W (W)
	) u_mask (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_valid  (scaled_valid_reg),
		.in_value  (scaled_reg),
		.weight    (weight),
		.out_value (mask_value),
		.out_valid (mask_valid)
	);

	// Reply value in hundredths: sign plus 5.2 digit field
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reply_value <= {W{1'b0}};
			reply_valid <= 1'b0;
		end else begin
			reply_valid <= mask_valid;
			if (mask_valid)
				reply_value <= mask_value;
		end
	end
endmodule // sofc_top
`default_nettype wire

// *** shared/sofc_defines.vh ***
`ifndef SOFC_DEFINES_VH
`define SOFC_DEFINES_VH
// Alarm and option setup byte fields
`define SOFC_OPT_RESET      8'h01
`define SOFC_OPT_ALARM_EN   7
`define SOFC_OPT_LO_LATCH   6
`define SOFC_OPT_HI_LATCH   5
`define SOFC_OPT_SENSOR     4
`define SOFC_OPT_FAHR       3
`define SOFC_OPT_ECHO       2
`define SOFC_OPT_DLY_HI     1
`define SOFC_OPT_DLY_LO     0
// Digits and filter setup byte fields
`define SOFC_DIG_RESET      8'hC2
`define SOFC_DIG_NDIG_HI    7
`define SOFC_DIG_NDIG_LO    6
`define SOFC_DIG_LARGE_HI   5
`define SOFC_DIG_LARGE_LO   3
`define SOFC_DIG_SMALL_HI   2
`define SOFC_DIG_SMALL_LO   0
// Serial characters
`define SOFC_CHAR_CR        8'h0D
`define SOFC_CHAR_LF        8'h0A
// Readings are counted in hundredths; weight of the least shown digit
`define SOFC_WEIGHT_4DIG    24'h0003E8
`define SOFC_WEIGHT_5DIG    24'h000064
`define SOFC_WEIGHT_6DIG    24'h00000A
`define SOFC_WEIGHT_7DIG    24'h000001
// Large-signal threshold is this many counts of the least shown digit
`define SOFC_THRESH_COUNTS  24'h00000A
// Fahrenheit offset, 32.00 degrees in hundredths
`define SOFC_FAHR_OFFSET    24'h000C80
`endif

// *** hw/sofc_filter.v ***
`default_nettype none
module sofc_filter #(
	parameter W         = 24,
	parameter FRAC      = 8,
	parameter SHIFT_OFS = 1
) (
	input  wire                clk,
	input  wire                arst_n,
	input  wire                sample_valid,
	input  wire signed [W-1:0] sample,
	input  wire [2:0]          large_code,
	input  wire [2:0]          small_code,
	input  wire [W-1:0]        thresh,
	output reg  signed [W-1:0] filt_value,
	output reg                 filt_valid,
	output reg                 large_sel
);
	reg  signed [W+FRAC-1:0] acc_reg;
	reg                      primed_reg;
	wire signed [W-1:0]      last_out = acc_reg[W+FRAC-1:FRAC];
	wire signed [W:0]        diff = {sample[W-1], sample} -
	                                {last_out[W-1], last_out};
	wire [W:0]               mag = diff[W] ? -diff : diff;
	// Exactly ten counts stays on the small constant
	wire                     big = mag > {1'b0, thresh};
	wire [2:0]               code = big ? large_code : small_code;
	// Signed operand so a falling reading shifts in ones, not zeros
	wire signed [W+FRAC:0]   step = $signed({diff, {FRAC{1'b0}}}) >>>
	                                (code + SHIFT_OFS - 1);
	wire signed [W+FRAC:0]   sum = {acc_reg[W+FRAC-1], acc_reg} + step;

	// Single-pole low pass, alpha = 2^-shift per conversion
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_reg <= {(W+FRAC){1'b0}};
			primed_reg <= 1'b0;
			filt_value <= {W{1'b0}};
			filt_valid <= 1'b0;
			large_sel <= 1'b0;
		end else begin
			filt_valid <= sample_valid;
			if (sample_valid) begin
				primed_reg <= 1'b1;
				large_sel <= big;
				if (!primed_reg || code == 3'h0) begin
					acc_reg <= {sample, {FRAC{1'b0}}};
					filt_value <= sample;
				end else begin
					acc_reg <= sum[W+FRAC-1:0];
					filt_value <= sum[W+FRAC-1:FRAC];
				end
			end
		end
	end
endmodule // sofc_filter
`default_nettype wire

// *** hw/sofc_mask.v ***
`default_nettype none
module sofc_mask #(
	parameter W = 24
) (
	input  wire                clk,
	input  wire                arst_n,
	input  wire                in_valid,
	input  wire signed [W-1:0] in_value,
	input  wire [W-1:0]        weight,
	output reg  signed [W-1:0] out_value,
	output reg                 out_valid
);
	wire [W-1:0] mag = in_value[W-1] ? -in_value : in_value;
	// Truncate toward zero so the sign of the reading survives
	wire [W-1:0] kept = mag - (mag % weight);

	// Trailing masked digits forced to zero
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			out_value <= {W{1'b0}};
			out_valid <= 1'b0;
		end else begin
			out_valid <= in_valid;
			if (in_valid)
				out_value <= in_value[W-1] ? -kept : kept;
		end
	end
endmodule // sofc_mask
`default_nettype wire

// *** verif/sofc_host.sv ***
`default_nettype none
module sofc_host #(
	parameter bit MULTIDROP = 1'b0
) (
	input  wire logic       clk,
	input  wire logic       variant_temp,
	output var  logic       setup_wr,
	output var  logic [7:0] setup_opt_in,
	output var  logic [7:0] setup_dig_in,
	output var  logic       rx_valid,
	output var  logic [7:0] rx_char
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{setup_wr, rx_valid} = 2'h0;
		{setup_opt_in, setup_dig_in, rx_char} = 24'h0;
	end
	// The write enable goes out on the line first; it has no pin here
	task automatic wr_setup(input logic [7:0] o, input logic [7:0] d);
		setup_wr = 1'b1;
		setup_opt_in = (variant_temp ? o : o & 8'hF7) &
			(MULTIDROP ? 8'hFB : 8'hFF);
		setup_dig_in = d;
		@(posedge clk) #5;
		setup_wr = 1'b0;
		setup_opt_in = ~setup_opt_in;
		setup_dig_in = ~setup_dig_in;
		@(posedge clk) #5;
	endtask
	// More keeps the strobe up so characters can follow back to back
	task automatic put_char(input logic [7:0] c, input logic more);
		rx_valid = 1'b1;
		rx_char = c;
		@(posedge clk) #5;
		if (!more) begin
			rx_valid = 1'b0;
			rx_char = ~c;
		end
	endtask
endmodule // sofc_host
`default_nettype wire

// *** verif/sofc_checker.sv ***
`default_nettype none
module sofc_checker (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       alarm_enable_command,
	input wire logic       alarm_disable_command,
	input wire logic [1:0] do_cmd,
	input wire logic       variant_temp,
	input wire logic       rx_valid,
	input wire logic [7:0] rx_char,
	input wire logic       resp_request,
	input wire logic       sample_valid,
	input wire logic       read_req,
	input wire logic [7:0] setup_opt,
	input wire logic [7:0] setup_dig,
	input wire logic [1:0] terminal_out,
	input wire logic       latch_lo,
	input wire logic       latch_hi,
	input wire logic       fahrenheit,
	input wire logic       echo_valid,
	input wire logic       cmd_char_valid,
	input wire logic       cmd_end,
	input wire logic       resp_wait,
	input wire logic       resp_start,
	input wire logic       filt_valid,
	input wire logic       reply_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	chk_reset_values: assert property ($rose(arst_n) |->
		setup_opt == 8'h01 && setup_dig == 8'hC2) else $error("reset value");
	chk_terminal_do: assert property ($past(arst_n) && !setup_opt[7] |->
		terminal_out == $past(do_cmd)) else $error("terminal route");
	chk_latch_bits: assert property (latch_lo == setup_opt[6] &&
		latch_hi == setup_opt[5]) else $error("latch bits");
	chk_enable_sets: assert property (alarm_enable_command &&
		!alarm_disable_command |-> ##2 setup_opt[7]) else $error("enable");
	chk_disable_clears: assert property (alarm_disable_command |->
		##2 !setup_opt[7]) else $error("disable");
	chk_echo_follow: assert property (rx_valid |=>
		echo_valid == setup_opt[2]) else $error("echo");
	chk_cr_ends: assert property (rx_valid && rx_char == 8'h0D |=>
		cmd_end && !cmd_char_valid) else $error("carriage return");
	chk_lf_dropped: assert property (rx_valid && rx_char == 8'h0D ##1
		rx_valid && rx_char == 8'h0A |=> !cmd_char_valid) else $error("lf");
	chk_zero_delay: assert property (resp_request && !resp_wait ##1
		setup_opt[1:0] == 2'h0 |=> resp_start) else $error("zero delay");
	chk_no_early: assert property (resp_request && !resp_wait ##1
		setup_opt[1:0] != 2'h0 |=> !resp_start) else $error("early start");
	chk_fahr_gate: assert property ($past(arst_n) |->
		fahrenheit == (setup_opt[3] && $past(variant_temp))) else $error("fahr");
	chk_filt_latency: assert property (sample_valid |->
		##2 filt_valid) else $error("filter latency");
	chk_reply_latency: assert property (read_req |->
		##3 reply_valid) else $error("reply latency");
endmodule // sofc_checker

bind sofc_top sofc_checker sofc_checker_inst (
	.clk, .arst_n, .alarm_enable_command, .alarm_disable_command, .do_cmd,
	.variant_temp, .rx_valid, .rx_char, .resp_request, .sample_valid,
	.read_req, .setup_opt, .setup_dig, .terminal_out, .latch_lo, .latch_hi,
	.fahrenheit, .echo_valid, .cmd_char_valid, .cmd_end, .resp_wait,
	.resp_start, .filt_valid, .reply_valid
);
`default_nettype wire

// *** verif/test_setup_option_filter_control.sv ***
`default_nettype none
module test_setup_option_filter_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clk, arst_n, setup_wr, rx_valid, resp_request;
	logic               alarm_enable_command, alarm_disable_command;
	logic               low_alarm_command, high_alarm_command, read_req;
	logic               low_latch_in, high_latch_in, alarm_lo, alarm_hi;
	logic               variant_tc, variant_rtd, variant_temp, sample_valid;
	logic               latch_lo, latch_hi, cjc_disable, four_wire, cmd_end;
	logic               fahrenheit, echo_valid, cmd_char_valid, resp_wait;
	logic               resp_start, filt_valid, large_sel, reply_valid;
	logic [1:0]         do_cmd, terminal_out;
	logic [7:0]         setup_opt_in, setup_dig_in, rx_char, setup_opt;
	logic [7:0]         setup_dig, echo_char, cmd_char;
	logic [19:0]        char_time;
	logic signed [23:0] sample, filt_out, reply_value;
	int                 miscompares, n_compared;

	sofc_top #(.W(24), .FRAC(8), .SHIFT_OFS(1), .CW(20)) sofc_top_inst (
		.clk, .arst_n, .setup_wr, .setup_opt_in, .setup_dig_in,
		.alarm_enable_command, .alarm_disable_command, .low_alarm_command,
		.low_latch_in, .high_alarm_command, .high_latch_in, .variant_tc,
		.variant_rtd, .variant_temp, .do_cmd, .alarm_lo, .alarm_hi, .rx_valid,
		.rx_char, .char_time, .resp_request, .sample_valid, .sample, .read_req,
		.setup_opt, .setup_dig, .terminal_out, .latch_lo, .latch_hi,
		.cjc_disable, .four_wire, .fahrenheit, .echo_valid, .echo_char,
		.cmd_char_valid, .cmd_char, .cmd_end, .resp_wait, .resp_start,
		.filt_out, .filt_valid, .large_sel, .reply_value, .reply_valid
	);
	sofc_host host (.clk, .variant_temp, .setup_wr, .setup_opt_in,
		.setup_dig_in, .rx_valid, .rx_char);

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(posedge clk) #5;
		s = 1'b0;
		@(posedge clk) #5;
	endtask
	task automatic put_sample(input logic [23:0] v);
		sample_valid = 1'b1;
		sample = v;
		@(posedge clk) #5;
		sample_valid = 1'b0;
		sample = ~v;
		@(posedge clk) #5;
	endtask
	task automatic rd(input logic [23:0] e);
		read_req = 1'b1;
		@(posedge clk) #5;
		read_req = 1'b0;
		repeat (2) @(posedge clk);
		#5;
		chk("reply_valid", 32'h1, reply_valid);
		chk("reply", {8'h0, e}, {8'h0, reply_value});
	endtask
	function automatic logic [31:0] rx_seen();
		return {13'h0, echo_valid, cmd_char_valid, cmd_end,
			echo_valid ? echo_char : 8'h00, cmd_char_valid ? cmd_char : 8'h00};
	endfunction

	task automatic t_fields();
		chk("opt", 32'h1, setup_opt);
		host.wr_setup(8'h18, 8'h3F);
		chk("dig", 32'h3F, setup_dig);
		chk("sensor", 32'h5, {cjc_disable, four_wire, fahrenheit});
		{variant_tc, variant_rtd, variant_temp} = 3'h2;
		host.wr_setup(8'h18, 8'h3F);
		chk("opt", 32'h10, setup_opt);
		chk("sensor", 32'h2, {cjc_disable, four_wire, fahrenheit});
		chk("terminal", 32'h1, terminal_out);
	endtask
	task automatic t_cmds();
		pulse(alarm_enable_command);
		chk("terminal", 32'h2, terminal_out);
		pulse(low_alarm_command);
		high_latch_in = 1'b1;
		pulse(high_alarm_command);
		chk("latch", 32'h3, {latch_lo, latch_hi});
		// Both at once: disable must win
		{alarm_enable_command, alarm_disable_command} = 2'h3;
		@(posedge clk) #5;
		{alarm_enable_command, alarm_disable_command} = 2'h0;
		low_latch_in = 1'b0;
		pulse(low_alarm_command);
		chk("opt", 32'h30, setup_opt);
	endtask
	task automatic t_serial();
		host.wr_setup(8'h05, 8'hC2);
		host.put_char(8'h41, 1'b1);
		chk("rx", 32'h64141, rx_seen());
		host.put_char(8'h0D, 1'b1);
		chk("rx", 32'h50D00, rx_seen());
		host.put_char(8'h0A, 1'b0);
		chk("rx", 32'h40A00, rx_seen());
		host.wr_setup(8'h01, 8'hC2);
		host.put_char(8'h42, 1'b1);
		chk("rx", 32'h20042, rx_seen());
		host.put_char(8'h0A, 1'b0);
		chk("rx", 32'h2000A, rx_seen());
	endtask
	task automatic t_delay();
		int n;
		for (int k = 0; k < 4; k++) begin
			host.wr_setup(8'(k), 8'hC2);
			resp_request = 1'b1;
			@(posedge clk) #5;
			resp_request = 1'b0;
			chk("resp_wait", 32'h1, resp_wait);
			n = 1;
			while (resp_start !== 1'b1 && n < 100) begin
				@(posedge clk) #5;
				n++;
			end
			if (n == 100) begin
				miscompares++;
				test_done();
			end
			chk("delay", 2 + 6 * k, n);
		end
	endtask
	task automatic t_filter();
		host.wr_setup(8'h00, 8'h87);
		put_sample(24'h002710);
		chk("filt", 32'h2710, filt_out);
		put_sample(24'h002AF8);
		chk("filt", 32'h1002AF8, {large_sel, filt_out});
		host.wr_setup(8'h00, 8'h47);
		put_sample(-24'h001388);
		put_sample(-24'h000F75);
		chk("filt", {8'h1, -24'h000F75}, {large_sel, filt_out});
		rd(-24'h000F3C);
		variant_temp = 1'b1;
		host.wr_setup(8'h08, 8'hC7);
		rd(-24'h000F52);
		chk("filt", {8'h0, -24'h000F75}, {8'h0, filt_out});
		host.wr_setup(8'h00, 8'h47);
		// Exactly ten counts of the last digit stays on the slow constant
		put_sample(-24'h000B8D);
		chk("large", 32'h0, large_sel);
		chk("move", {8'h0, -24'h000F6E}, {8'h0, filt_out});
		// Falling step on the small constant pulls the output back down
		put_sample(-24'h001356);
		chk("filt", {8'h0, -24'h000F75}, {large_sel, filt_out});
		host.wr_setup(8'h00, 8'h07);
		rd(-24'h000BB8);
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{miscompares, n_compared} = 64'h0;
		arst_n = 1'b0;
		{alarm_enable_command, alarm_disable_command} = 2'h0;
		{low_alarm_command, high_alarm_command} = 2'h0;
		{resp_request, sample_valid, read_req} = 3'h0;
		{low_latch_in, high_latch_in, alarm_lo, alarm_hi} = 4'h9;
		{variant_tc, variant_rtd, variant_temp} = 3'h5;
		do_cmd = 2'h1;
		sample = 24'h000000;
		char_time = 20'h00003;
		repeat (8) @(posedge clk);
		#5;
		arst_n = 1'b1;
		t_fields();
		t_cmds();
		t_serial();
		t_delay();
		t_filter();
		test_done();
	end
endmodule // test_setup_option_filter_control
`default_nettype wire
